// file: src/qqs_pkg.sv
// Purpose: shared constants, types and helpers of the qos queue map and scheduler
// Assumes: avalon word address equals the register index
// Notes: one register per 32-bit word, narrower data in the low bits
package qqs_pkg;
  localparam int          NPORT       = 17;
  localparam int          NQ          = 4;
  localparam int          STRAP_PORTS = 8;
  localparam logic [7:0]  IDX_MAP0    = 8'h50;
  localparam logic [7:0]  IDX_MAPN    = 8'h70;
  localparam logic [7:0]  IDX_TXCTL   = 8'h80;
  localparam logic [7:0]  IDX_WGT0    = 8'h81;
  localparam logic [7:0]  IDX_WGT3    = 8'h84;
  localparam logic [7:0]  IDX_ETYPE   = 8'h88;
  localparam int          TX_PREEMPT  = 4;
  localparam int          TX_MODE_LSB = 2;
  localparam int          ET_EN_BIT   = 18;
  localparam int          ET_Q_LSB    = 16;
  localparam logic [15:0] MAP_STRAP   = 16'hFFFF;
  localparam logic [15:0] MAP_PLAIN   = 16'h0000;
  localparam logic [31:0] WGT_RST     = 32'h08040201;
  localparam logic [1:0]  TXRSV_RST   = 2'h0;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'h1,
    BUS_FETCH = 3'h2,
    BUS_DONE  = 3'h4
  } qqs_bus_st_t;

  // queue field of one priority id inside a port map word
  function automatic logic [1:0] qqs_prio_queue(input logic [15:0] map, input logic [2:0] prio);
    qqs_prio_queue = map[{prio, 1'b0} +: 2];
  endfunction : qqs_prio_queue

  // byte-enable merge of a write into an old register value
  function automatic logic [31:0] qqs_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    qqs_merge = r;
  endfunction : qqs_merge
endpackage : qqs_pkg

// file: src/qqs_cfg_if.sv
// Purpose: scheduler configuration carried from the register file
// Assumes: driven from flip-flops of the top
// Notes: none
`timescale 1ns/10ps
interface qqs_cfg_if;
  logic            preempt;
  logic [1:0]      mode;
  logic [3:0][7:0] wgt;
  modport src   (output preempt, output mode, output wgt);
  modport sched (input preempt, input mode, input wgt);
endinterface : qqs_cfg_if

// file: src/qqs_map_mem.sv
// Purpose: per-port priority to queue map store, one write and two read ports
// Assumes: load_def is a single pulse after reset release, no write in that cycle
// Notes: read data come from registers, one cycle after the index
`timescale 1ns/10ps
module qqs_map_mem (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // strap defaults
  input  wire logic        load_def,
  input  wire logic        qos_strap,
  // write port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  // read ports
  input  wire logic [4:0]  ra_idx,
  output logic      [15:0] ra_data_ff,
  input  wire logic [4:0]  rb_idx,
  output logic      [15:0] rb_data_ff
);
  typedef struct packed {
    logic [16:0][15:0] map;
    logic [15:0]       ra;
    logic [15:0]       rb;
  } qqs_mem_st_t;

  qqs_mem_st_t st_ff;
  qqs_mem_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    // strap defaults
    if (load_def)
    begin
      for (int p = 0; p < qqs_pkg::NPORT; p++)
        nxt_st.map[p] = (p < qqs_pkg::STRAP_PORTS && qos_strap) ? qqs_pkg::MAP_STRAP : qqs_pkg::MAP_PLAIN;
    end
    if (wr_en && wr_idx < 5'(qqs_pkg::NPORT))
      nxt_st.map[wr_idx] = wr_data;
    nxt_st.ra = (ra_idx < 5'(qqs_pkg::NPORT)) ? st_ff.map[ra_idx] : 16'h0000;
    nxt_st.rb = (rb_idx < 5'(qqs_pkg::NPORT)) ? st_ff.map[rb_idx] : 16'h0000;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign ra_data_ff = st_ff.ra;
  assign rb_data_ff = st_ff.rb;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_strap_def;
    load_def |=> st_ff.map[0] == {16{$past(qos_strap)}} && st_ff.map[7] == {16{$past(qos_strap)}}
                 && st_ff.map[8] == 16'h0000 && st_ff.map[16] == 16'h0000;
  endproperty
  a_strap_def: assert property (p_strap_def) else $error("strap defaults of port map wrong");

  property p_map_read;
    (rb_idx < 5'(qqs_pkg::NPORT) && !wr_en && !load_def) |=> rb_data_ff == $past(st_ff.map[rb_idx]);
  endproperty
  a_map_read: assert property (p_map_read) else $error("port map read data wrong");
endmodule : qqs_map_mem

// file: src/qqs_wrr_sched.sv
// Purpose: egress queue selection by weighted round-robin with top-queue preemption
// Assumes: q_ready bit set while that queue holds a frame
// Notes: at most one grant per slot_req, one cycle later; weight 0 acts as 1
`timescale 1ns/10ps
module qqs_wrr_sched (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // configuration
  qqs_cfg_if.sched        cfg,
  // queue state and slot request
  input  wire logic [3:0] q_ready,
  input  wire logic       slot_req,
  // grant
  output logic            grant_valid_ff,
  output logic      [1:0] grant_queue_ff
);
  typedef struct packed {
    logic [1:0] ptr;
    logic [7:0] credit;
    logic       gv;
    logic [1:0] gq;
  } qqs_sch_st_t;

  qqs_sch_st_t st_ff;
  qqs_sch_st_t nxt_st;
  logic [3:0]  elig;
  logic        top_hit;

  always_comb
  begin
    logic [1:0] idx;
    logic [1:0] cand;
    logic [7:0] wl;
    logic       found;
    logic       reload;
    idx = 2'h0;
    wl = 8'h00;
    nxt_st = st_ff;
    nxt_st.gv = 1'b0;
    found = 1'b0;
    reload = 1'b0;
    cand = st_ff.ptr;
    for (int i = 0; i < qqs_pkg::NQ; i++)
      elig[i] = q_ready[i] && (2'(i) <= cfg.mode) && !(cfg.preempt && 2'(i) == cfg.mode);
    top_hit = cfg.preempt && q_ready[cfg.mode];
    if (elig[st_ff.ptr] && st_ff.credit != 8'h00)
      found = 1'b1;
    for (int k = 1; k <= qqs_pkg::NQ; k++)
    begin
      idx = st_ff.ptr + 2'(k);
      if (!found && elig[idx])
      begin
        found = 1'b1;
        reload = 1'b1;
        cand = idx;
      end
    end
    wl = (cfg.wgt[cand] == 8'h00) ? 8'h01 : cfg.wgt[cand];
    if (slot_req)
    begin
      if (top_hit)
      begin
        nxt_st.gv = 1'b1;
        nxt_st.gq = cfg.mode;
      end
      else if (found)
      begin
        nxt_st.gv = 1'b1;
        nxt_st.gq = cand;
        nxt_st.ptr = cand;
        nxt_st.credit = reload ? wl - 8'h01 : st_ff.credit - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign grant_valid_ff = st_ff.gv;
  assign grant_queue_ff = st_ff.gq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_preempt;
    slot_req && top_hit |=> grant_valid_ff && grant_queue_ff == $past(cfg.mode);
  endproperty
  a_preempt: assert property (p_preempt) else $error("top queue not served first");

  property p_lower_wrr;
    slot_req && cfg.preempt && !q_ready[cfg.mode] && |elig
      |=> grant_valid_ff && |($past(elig) & (4'h1 << grant_queue_ff));
  endproperty
  a_lower_wrr: assert property (p_lower_wrr) else $error("lower queue not served");

  property p_plain_wrr;
    slot_req && !cfg.preempt && |elig |=> grant_valid_ff && |($past(q_ready) & (4'h1 << grant_queue_ff))
                                         && grant_queue_ff <= $past(cfg.mode);
  endproperty
  a_plain_wrr: assert property (p_plain_wrr) else $error("grant to an idle or inactive queue");

  c_preempt: cover property (slot_req && top_hit ##1 grant_valid_ff);
  c_switch:  cover property (grant_valid_ff ##1 grant_valid_ff && $changed(grant_queue_ff));
endmodule : qqs_wrr_sched

// file: src/qqs_top.sv
// Purpose: qos queue map, queue mode, weights and ethertype steering with avalon registers
// Assumes: avalon-mm slave with waitrequest, word addresses, inputs synchronous to clk_sys
// Notes: strap defaults load in the first cycle after reset release
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module qqs_top (
  // clock, reset, strap
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        qos_strap,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // frame classification
  input  wire logic        cls_valid,
  input  wire logic [4:0]  cls_port,
  input  wire logic [2:0]  cls_prio,
  input  wire logic [15:0] cls_etype,
  output logic             cls_done,
  output logic      [1:0]  cls_queue,
  // egress scheduling
  input  wire logic [3:0]  q_ready,
  input  wire logic        slot_req,
  output logic             grant_valid,
  output logic      [1:0]  grant_queue,
  // flow control
  output logic      [1:0]  fc_queue_mode
);
  typedef struct packed {
    qqs_pkg::qqs_bus_st_t bus;
    logic                 wreq;
    logic [31:0]          rdata;
    logic                 preempt;
    logic [1:0]           mode;
    logic [1:0]           txrsv;
    logic [3:0][7:0]      wgt;
    logic                 et_en;
    logic [1:0]           et_q;
    logic [15:0]          et_val;
    logic                 init;
    logic                 cls_pend;
    logic                 et_hit;
    logic [1:0]           et_qs;
    logic [2:0]           prio;
    logic                 cls_vld;
    logic [1:0]           cls_q;
  } qqs_top_st_t;

  qqs_top_st_t st_ff;
  qqs_top_st_t nxt_st;

  logic        is_map;
  logic        is_tx;
  logic        is_wgt;
  logic        is_et;
  logic [4:0]  map_idx;
  logic [1:0]  wgt_idx;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic        map_wr;
  logic [15:0] mem_a_q;
  logic [15:0] mem_b_q;

  qqs_cfg_if cfg_if ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    logic [7:0] off;
    off = avs_address - qqs_pkg::IDX_MAP0;
    is_map = avs_address >= qqs_pkg::IDX_MAP0 && avs_address <= qqs_pkg::IDX_MAPN && !avs_address[0];
    is_tx = avs_address == qqs_pkg::IDX_TXCTL;
    is_wgt = avs_address >= qqs_pkg::IDX_WGT0 && avs_address <= qqs_pkg::IDX_WGT3;
    is_et = avs_address == qqs_pkg::IDX_ETYPE;
    map_idx = off[5:1];
    wgt_idx = 2'(avs_address - qqs_pkg::IDX_WGT0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (is_map)
      rd_mux = {16'h0000, mem_a_q};
    else if (is_tx)
      rd_mux = {27'h0, st_ff.preempt, st_ff.mode, st_ff.txrsv};
    else if (is_wgt)
      rd_mux = {24'h0, st_ff.wgt[wgt_idx]};
    else if (is_et)
      rd_mux = {13'h0, st_ff.et_en, st_ff.et_q, st_ff.et_val};
  end

  assign wr_val = qqs_pkg::qqs_merge(rd_mux, avs_writedata, avs_byteenable);
  assign map_wr = st_ff.bus == qqs_pkg::BUS_DONE && avs_write && is_map;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.init = 1'b1;
    if (!st_ff.init)
      nxt_st.mode = {qos_strap, qos_strap};
    case (st_ff.bus)
      qqs_pkg::BUS_IDLE:
      begin
        if (st_ff.init && (avs_read || avs_write))
          nxt_st.bus = qqs_pkg::BUS_FETCH;
      end
      qqs_pkg::BUS_FETCH:
      begin
        nxt_st.bus = qqs_pkg::BUS_DONE;
        nxt_st.wreq = 1'b0;
        nxt_st.rdata = rd_mux;
      end
      qqs_pkg::BUS_DONE:
      begin
        nxt_st.bus = qqs_pkg::BUS_IDLE;
        nxt_st.wreq = 1'b1;
        if (avs_write)
        begin
          if (is_tx)
          begin
            nxt_st.preempt = wr_val[qqs_pkg::TX_PREEMPT];
            nxt_st.mode = wr_val[qqs_pkg::TX_MODE_LSB +: 2];
            nxt_st.txrsv = wr_val[1:0];
          end
          if (is_wgt)
            nxt_st.wgt[wgt_idx] = wr_val[7:0];
          if (is_et)
          begin
            nxt_st.et_en = wr_val[qqs_pkg::ET_EN_BIT];
            nxt_st.et_q = wr_val[qqs_pkg::ET_Q_LSB +: 2];
            nxt_st.et_val = wr_val[15:0];
          end
        end
      end
      default:
      begin
        nxt_st.bus = qqs_pkg::BUS_IDLE;
        nxt_st.wreq = 1'b1;
      end
    endcase
    // classification, two-stage
    nxt_st.cls_pend = cls_valid;
    nxt_st.prio = cls_prio;
    nxt_st.et_hit = st_ff.et_en && cls_etype == st_ff.et_val;
    nxt_st.et_qs = st_ff.et_q;
    nxt_st.cls_vld = st_ff.cls_pend;
    if (st_ff.cls_pend)
      nxt_st.cls_q = st_ff.et_hit ? st_ff.et_qs : qqs_pkg::qqs_prio_queue(mem_b_q, st_ff.prio);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
      st_ff.bus <= qqs_pkg::BUS_IDLE;
      st_ff.wreq <= 1'b1;
      st_ff.txrsv <= qqs_pkg::TXRSV_RST;
      st_ff.wgt <= qqs_pkg::WGT_RST;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  // strap defaults after release
  qqs_map_mem u_map (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .load_def   (!st_ff.init),
    .qos_strap  (qos_strap),
    .wr_en      (map_wr),
    .wr_idx     (map_idx),
    .wr_data    (wr_val[15:0]),
    .ra_idx     (map_idx),
    .ra_data_ff (mem_a_q),
    .rb_idx     (cls_port),
    .rb_data_ff (mem_b_q)
  );

  assign cfg_if.preempt = st_ff.preempt;
  assign cfg_if.mode = st_ff.mode;
  assign cfg_if.wgt = st_ff.wgt;

  qqs_wrr_sched u_sched (
    .clk_sys        (clk_sys),
    .nrst           (nrst),
    .cfg            (cfg_if.sched),
    .q_ready        (q_ready),
    .slot_req       (slot_req),
    .grant_valid_ff (grant_valid),
    .grant_queue_ff (grant_queue)
  );

  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.wreq;
  assign cls_done = st_ff.cls_vld;
  assign cls_queue = st_ff.cls_q;
  assign fc_queue_mode = st_ff.mode;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_bus_answer;
    st_ff.bus == qqs_pkg::BUS_IDLE && st_ff.init && (avs_read || avs_write)
      |-> avs_waitrequest [*2] ##1 !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

  property p_mode_strap;
    $rose(st_ff.init) |-> st_ff.mode == {2{$past(qos_strap)}};
  endproperty
  a_mode_strap: assert property (p_mode_strap) else $error("queue mode not taken from strap");

  property p_wgt_rst;
    $rose(st_ff.init) |-> st_ff.wgt == qqs_pkg::WGT_RST && !st_ff.et_en;
  endproperty
  a_wgt_rst: assert property (p_wgt_rst) else $error("weight or ethertype reset wrong");

  property p_et_rst;
    $rose(st_ff.init) |-> st_ff.et_en == 1'b0 && st_ff.et_val == 16'h0000;
  endproperty
  a_et_rst: assert property (p_et_rst) else $error("ethertype enable not clear at reset");

  property p_et_steer;
    cls_valid && st_ff.et_en && cls_etype == st_ff.et_val
      |-> ##2 cls_done && cls_queue == $past(st_ff.et_q, 2);
  endproperty
  a_et_steer: assert property (p_et_steer) else $error("ethertype frame not steered");

  property p_map_lookup;
    cls_valid && !(st_ff.et_en && cls_etype == st_ff.et_val) && !map_wr
      |=> ##1 cls_done && cls_queue == qqs_pkg::qqs_prio_queue($past(mem_b_q), $past(st_ff.prio));
  endproperty
  a_map_lookup: assert property (p_map_lookup) else $error("priority map lookup wrong");

  property p_rsv_zero;
    !avs_waitrequest && $past(is_tx) |-> avs_readdata[31:5] == 27'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

  property p_fc_mode;
    st_ff.bus == qqs_pkg::BUS_DONE && avs_write && is_tx && avs_byteenable[0]
      |=> fc_queue_mode == $past(avs_writedata[3:2]);
  endproperty
  a_fc_mode: assert property (p_fc_mode) else $error("flow-control mode not updated");

  c_bus_write: cover property (st_ff.bus == qqs_pkg::BUS_DONE && avs_write && is_wgt);
  c_et_hit:    cover property (st_ff.cls_pend && st_ff.et_hit);
  c_map_read:  cover property (st_ff.bus == qqs_pkg::BUS_DONE && avs_read && is_map);
endmodule : qqs_top

// file: tb/qqs_tb.sv
// Purpose: self-checking bench of the qos queue map and scheduler
// Assumes: bus answer and classify latency as the design hand-over states
// Notes: round-robin judged by run lengths, first and open last run skipped
`timescale 1ns/10ps
module testbench;
  logic            clk_sys;
  logic            nrst;
  logic            qos_strap;
  logic [7:0]      avs_address;
  logic            avs_read;
  logic            avs_write;
  logic [3:0]      avs_byteenable;
  logic [31:0]     avs_writedata;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic            cls_valid;
  logic [4:0]      cls_port;
  logic [2:0]      cls_prio;
  logic [15:0]     cls_etype;
  logic            cls_done;
  logic [1:0]      cls_queue;
  logic [3:0]      q_ready;
  logic            slot_req;
  logic            grant_valid;
  logic [1:0]      grant_queue;
  logic [1:0]      fc_queue_mode;
  logic [3:0][7:0] wgt;
  int              num_errors;
  int              compares;

  always #12.5 clk_sys = ~clk_sys;

  qqs_top dut (
    .clk_sys         (clk_sys),
    .nrst            (nrst),
    .qos_strap       (qos_strap),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .cls_valid       (cls_valid),
    .cls_port        (cls_port),
    .cls_prio        (cls_prio),
    .cls_etype       (cls_etype),
    .cls_done        (cls_done),
    .cls_queue       (cls_queue),
    .q_ready         (q_ready),
    .slot_req        (slot_req),
    .grant_valid     (grant_valid),
    .grant_queue     (grant_queue),
    .fc_queue_mode   (fc_queue_mode)
  );

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // request held until waitrequest is sampled low
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    chk(name, exp, avs_readdata);
    avs_read <= 1'b0;
  endtask : rd_chk

  task automatic classify(input logic [4:0] p, input logic [2:0] pr, input logic [15:0] et,
                          input logic [1:0] exp);
    @(posedge clk_sys);
    cls_valid <= 1'b1;
    cls_port  <= p;
    cls_prio  <= pr;
    cls_etype <= et;
    @(posedge clk_sys);
    cls_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("cls_done", 32'h1, cls_done);
    chk("cls_queue", exp, cls_queue);
  endtask : classify

  task automatic slot(output logic v, output logic [1:0] q);
    @(posedge clk_sys);
    slot_req <= 1'b1;
    @(posedge clk_sys);
    slot_req <= 1'b0;
    @(posedge clk_sys);
    v = grant_valid;
    q = grant_queue;
  endtask : slot

  // every closed run of one queue after the first must last exactly its weight
  task automatic wrr_run(input logic [3:0] allow);
    logic       v;
    logic [1:0] q;
    logic [1:0] prev;
    int         len;
    bit         first;
    slot(v, prev);
    len   = 1;
    first = 1'b1;
    for (int n = 1; n < 40; n++)
    begin
      slot(v, q);
      chk("grant_valid", 32'h1, v);
      chk("grant_allowed", 32'h1, allow[q]);
      if (q === prev)
        len++;
      else
      begin
        if (!first)
          chk("wrr_run_length", wgt[prev], len);
        first = 1'b0;
        prev  = q;
        len   = 1;
      end
    end
  endtask : wrr_run

  ////////////////////////////////////////////////////////////////
  task automatic t_reset(input logic s);
    @(posedge clk_sys);
    nrst      <= 1'b0;
    qos_strap <= s;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd_chk("map_port0", 8'h50, {16'h0000, {16{s}}});
    rd_chk("map_port7", 8'h5E, {16'h0000, {16{s}}});
    rd_chk("map_port8", 8'h60, 32'h0);
    rd_chk("map_port16", 8'h70, 32'h0);
    rd_chk("txctl", 8'h80, {28'h0, s, s, 2'h0});
    chk("fc_queue_mode", {30'h0, s, s}, fc_queue_mode);
    for (int i = 0; i < 4; i++)
      rd_chk("weight", 8'(8'h81 + i), 32'h1 << i);
    rd_chk("etype_ctl", 8'h88, 32'h0);
    classify(5'h00, 3'h5, 16'h0800, {s, s});
  endtask : t_reset

  task automatic t_regs();
    bus_wr(8'h80, 32'hFFFFFFFF, 4'hF);
    rd_chk("txctl_rsv", 8'h80, 32'h0000001F);
    bus_wr(8'h88, 32'hFFFFFFFF, 4'hF);
    rd_chk("etype_rsv", 8'h88, 32'h0007FFFF);
    bus_wr(8'h51, 32'hFFFFFFFF, 4'hF);
    rd_chk("unmapped", 8'h51, 32'h0);
    bus_wr(8'h81, 32'h00000055, 4'h0);
    rd_chk("weight_be", 8'h81, 32'h1);
    bus_wr(8'h52, 32'h0000ABCD, 4'h1);
    rd_chk("map_be", 8'h52, 32'h000000CD);
    for (int m = 0; m < 4; m++)
    begin
      bus_wr(8'h80, 32'(m) << 2, 4'hF);
      rd_chk("txctl_mode", 8'h80, 32'(m) << 2);
      chk("fc_queue_mode", 32'(m), fc_queue_mode);
    end
    bus_wr(8'h88, 32'h0, 4'hF);
  endtask : t_regs

  task automatic t_cls();
    bus_wr(8'h56, 32'h0000E4E4, 4'hF);
    for (int p = 0; p < 8; p++)
      classify(5'h03, 3'(p), 16'h0800, 2'(p));
    classify(5'h10, 3'h7, 16'h88F7, 2'h0);
    bus_wr(8'h88, 32'h000288F7, 4'hF);
    classify(5'h03, 3'h0, 16'h88F7, 2'h0);
    for (int t = 0; t < 4; t++)
    begin
      bus_wr(8'h88, 32'h000488F7 | (32'(t) << 16), 4'hF);
      classify(5'h03, 3'h5, 16'h88F7, 2'(t));
      classify(5'h03, 3'h6, 16'h88F6, 2'h2);
    end
  endtask : t_cls

  task automatic t_sched();
    logic       v;
    logic [1:0] q;
    @(posedge clk_sys);
    q_ready <= 4'hF;
    wgt = {8'h08, 8'h04, 8'h02, 8'h01};
    bus_wr(8'h80, 32'h0000000C, 4'hF);
    wrr_run(4'hF);
    wgt = {8'h01, 8'h02, 8'h01, 8'h03};
    for (int i = 0; i < 4; i++)
      bus_wr(8'(8'h81 + i), 32'(wgt[i]), 4'hF);
    wrr_run(4'hF);
    bus_wr(8'h80, 32'h0000001C, 4'hF);
    wrr_run(4'h8);
    @(posedge clk_sys);
    q_ready <= 4'h7;
    wrr_run(4'h7);
    @(posedge clk_sys);
    q_ready <= 4'h0;
    slot(v, q);
    chk("no_grant", 32'h0, v);
    @(posedge clk_sys);
    q_ready <= 4'hF;
    bus_wr(8'h80, 32'h00000004, 4'hF);
    wrr_run(4'h3);
    bus_wr(8'h80, 32'h00000008, 4'hF);
    wrr_run(4'h7);
    bus_wr(8'h80, 32'h00000014, 4'hF);
    wrr_run(4'h2);
    bus_wr(8'h80, 32'h00000000, 4'hF);
    wrr_run(4'h1);
  endtask : t_sched

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys        = 1'b0;
    nrst           = 1'b0;
    qos_strap      = 1'b0;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata  = 32'h0;
    cls_valid      = 1'b0;
    cls_port       = 5'h00;
    cls_prio       = 3'h0;
    cls_etype      = 16'h0000;
    q_ready        = 4'h0;
    slot_req       = 1'b0;
    wgt            = '0;
    num_errors     = 0;
    compares       = 0;
    t_reset(1'b1);
    t_reset(1'b0);
    t_regs();
    t_cls();
    t_sched();
    conclude();
  end

  // watchdog well beyond the less than two thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
endmodule : testbench
